// [hdl/rpmc_pkg.sv]
// Constants and types shared by the radio power mode controller.
// Operation
// R1: Fault: safe mode, 250 ms blink, reboot 5 s later.
// R2: Fault condition blocks all radio transmit and receive.
// R3: After fault reboot, come up in readable safe mode.
// R4: Enable pin high with supply gives on state.
// R5: Enable pin low: off, clear volatile settings.
// R6: Light sleep: radio off, serial logic powered.
// R7: Wake on host line change lasting 10 us.
// R8: Send OK within 30 ms; host waits.
// R9: Stay awake until next sleep command.
// R10: Power save studies four good packets, shortest interval.
// R11: Update shortest interval after every good packet.
// R12: Margin equals shortest interval over 8 plus 60.
// R13: Sleep equals interval minus margin minus airtime.
// R14: Overlap is margin plus 100; slot bounds follow.
// R15: Restart study after 100 cycles or missed slot.
// R16: Host uses power save for steady one-way traffic.
// R17: Receive-ready searches sync, then receives data.
// R18: Restart command shuts circuitry, then reboots processor.
// R19: Status pin held low during light sleep.
// R20: Free-running millisecond counter stamps packet starts.
// R21: Safe mode timer starts at entry, requests reset.
package rpmc_pkg;

	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned HZ_PER_KHZ = 1000;
	localparam int unsigned HZ_PER_MHZ = 1_000_000;
	localparam int unsigned MS_CYC_DFLT = CLK_HZ / HZ_PER_KHZ;

	localparam int unsigned TMS_W = 16;
	localparam logic [TMS_W-1:0] MS_MAX = 16'hffff;

	localparam int unsigned BLINK_MS = 250;
	localparam int unsigned REBOOT_S = 5;
	localparam int unsigned REBOOT_MS = REBOOT_S * HZ_PER_KHZ;
	localparam int unsigned WAKE_PULSE_US = 10;
	localparam int unsigned WAKE_PULSE_CYC =
		(WAKE_PULSE_US * CLK_HZ + HZ_PER_MHZ - 1) / HZ_PER_MHZ;
	localparam int unsigned WAKE_OK_MS = 30;
	localparam int unsigned RESTART_HOLD_CYC = 16;

	localparam int unsigned MARG_SHIFT = 3;
	localparam logic [TMS_W-1:0] MARG_ADD_MS = 16'h003c;
	localparam logic [TMS_W-1:0] OVERLAP_ADD_MS = 16'h0064;
	localparam logic [2:0] STUDY_PKTS = 3'h4;
	localparam logic [6:0] CYCLE_LIMIT = 7'h64;

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_ON = 3'h1,
		ST_SLEEP = 3'h3,
		ST_FAULT = 3'h2,
		ST_SAFE = 3'h6,
		ST_RESTART = 3'h4
	} rpmc_state_e;

	typedef struct packed {
		logic radio_power;
		logic rx_search;
		logic rx_data;
		logic tx_active;
	} rpmc_radio_s;

	localparam rpmc_radio_s RADIO_IDLE = 4'h0;

endpackage

// [hdl/rpmc_div.sv]
// Clock divider that produces a one-cycle enable pulse.
`timescale 1ns/1ps
module rpmc_div #(
	parameter int unsigned DIV = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic tick
);
	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
		end else if (cnt == LAST) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 1'b0;
		end else begin
			tick <= (cnt == LAST);
		end
	end
endmodule

// [hdl/rpmc_top.sv]
// Operating and power state controller of the radio module.
`timescale 1ns/1ps
module rpmc_top
	import rpmc_pkg::*;
#(
	parameter int unsigned MS_CYC = MS_CYC_DFLT
) (
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic MODULE_ENABLE_PIN,
	input wire logic HOST_TRANSMIT_LINE,
	input wire logic FAULT_DETECT,
	input wire logic SLEEP_CMD,
	input wire logic RESTART_CMD,
	input wire logic PS_ENABLE,
	input wire logic TX_REQ,
	input wire logic SYNC_FOUND,
	input wire logic RX_DONE,
	input wire logic RX_GOOD,
	input wire logic [TMS_W-1:0] TX_AIRTIME_MS,
	output rpmc_radio_s RADIO,
	output logic SERIAL_POWER,
	output logic STATUS_PIN,
	output logic WAKE_OK,
	output logic FAULT_READABLE,
	output logic CPU_RESET_REQ,
	output logic SETTINGS_CLEAR,
	output logic PKT_LOST,
	output logic [TMS_W-1:0] PS_TMIN_MS
);
	logic rst_meta;
	logic rst_n;
	logic ms_tick;
	rpmc_state_e state;
	rpmc_state_e next_state;
	logic [TMS_W-1:0] ms_now;
	logic [TMS_W-1:0] safe_ms;
	logic [TMS_W-1:0] blink_ms;
	logic blink;
	logic reboot_due;
	logic [4:0] hold_cnt;
	logic restart_done;
	logic line_ref;
	logic [11:0] wake_cnt;
	logic wake;
	logic ok_pend;
	logic [TMS_W-1:0] ok_ms;
	logic rx_busy;
	logic tx_prev;
	logic radio_ok;
	logic ps_run;
	logic [TMS_W-1:0] start_ms;
	logic [TMS_W-1:0] last_start;
	logic have_last;
	logic [TMS_W-1:0] tmin;
	logic [2:0] pkt_cnt;
	logic [6:0] cyc_cnt;
	logic [TMS_W-1:0] sleep_left;
	logic ps_asleep;
	logic study_done;
	logic good_pkt;
	logic [TMS_W-1:0] ival;
	logic [TMS_W-1:0] marg;
	logic [TMS_W-1:0] overlap;
	logic [TMS_W-1:0] t_less_marg;
	logic [TMS_W-1:0] t_sleep;
	logic [TMS_W-1:0] since_last;
	logic slot_missed;
	logic study_restart;

	// Reset leaves through two flops so release is clean in this domain.
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	rpmc_div #(
		.DIV(MS_CYC)
	) i_rpmc_div (
		.clk(REF_CLK),
		.rst_n(rst_n),
		.tick(ms_tick)
	);

	// Free-running millisecond time base; wraps, differences stay valid.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ms_now <= '0;
		end else if (ms_tick) begin
			ms_now <= ms_now + 16'h0001; // [R20]
		end
	end

	assign reboot_due = (state == ST_FAULT) && ms_tick &&
		(safe_ms == TMS_W'(REBOOT_MS - 1));
	assign restart_done = (state == ST_RESTART) &&
		(hold_cnt == 5'(RESTART_HOLD_CYC - 1));

	always_comb begin
		next_state = state;
		unique case (state)
			ST_OFF: begin
				next_state = ST_ON; // [R4]
			end
			ST_ON: begin
				if (FAULT_DETECT) begin
					next_state = ST_FAULT; // [R1]
				end else if (RESTART_CMD) begin
					next_state = ST_RESTART; // [R18]
				end else if (SLEEP_CMD) begin
					next_state = ST_SLEEP; // [R9]
				end
			end
			ST_SLEEP: begin
				if (FAULT_DETECT) begin
					next_state = ST_FAULT;
				end else if (wake) begin
					next_state = ST_ON; // [R7]
				end
			end
			ST_FAULT: begin
				if (reboot_due) begin
					next_state = ST_SAFE; // [R3]
				end
			end
			ST_SAFE: begin
				if (RESTART_CMD) begin
					next_state = ST_RESTART;
				end
			end
			ST_RESTART: begin
				if (restart_done) begin
					next_state = ST_ON;
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
		if (!MODULE_ENABLE_PIN) begin
			next_state = ST_OFF; // [R5]
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// Reboot timer starts from zero at fault state entry.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			safe_ms <= '0;
		end else if (state != ST_FAULT) begin
			safe_ms <= '0;
		end else if (ms_tick) begin
			safe_ms <= safe_ms + 16'h0001; // [R21]
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			blink_ms <= '0;
			blink <= 1'b1;
		end else if (state != ST_FAULT && state != ST_SAFE) begin
			blink_ms <= '0;
			blink <= 1'b1;
		end else if (ms_tick) begin
			if (blink_ms == TMS_W'(BLINK_MS - 1)) begin
				blink_ms <= '0;
				blink <= !blink; // [R1]
			end else begin
				blink_ms <= blink_ms + 16'h0001;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt <= '0;
		end else if (state != ST_RESTART) begin
			hold_cnt <= '0;
		end else begin
			hold_cnt <= hold_cnt + 5'h01; // [R18]
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			CPU_RESET_REQ <= 1'b0;
		end else begin
			CPU_RESET_REQ <= reboot_due || restart_done; // [R21]
		end
	end

	// Any level held away from the sleep-entry level for 10 us wakes us.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			line_ref <= 1'b1;
		end else if (state != ST_SLEEP) begin
			line_ref <= HOST_TRANSMIT_LINE;
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			wake_cnt <= '0;
		end else if (state != ST_SLEEP || HOST_TRANSMIT_LINE == line_ref) begin
			wake_cnt <= '0;
		end else if (!wake) begin
			wake_cnt <= wake_cnt + 12'h001; // [R7]
		end
	end

	assign wake = (state == ST_SLEEP) && (HOST_TRANSMIT_LINE != line_ref) &&
		(wake_cnt == 12'(WAKE_PULSE_CYC - 1));

	// OK goes out one millisecond early so it lands inside the window.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ok_pend <= 1'b0;
			ok_ms <= '0;
			WAKE_OK <= 1'b0;
		end else begin
			WAKE_OK <= 1'b0;
			if (wake) begin
				ok_pend <= 1'b1;
				ok_ms <= '0;
			end else if (ok_pend && state != ST_ON) begin
				ok_pend <= 1'b0;
			end else if (ok_pend && ms_tick) begin
				if (ok_ms == TMS_W'(WAKE_OK_MS - 2)) begin
					ok_pend <= 1'b0;
					WAKE_OK <= 1'b1; // [R8]
				end else begin
					ok_ms <= ok_ms + 16'h0001;
				end
			end
		end
	end

	assign radio_ok = (state == ST_ON) && !ps_asleep; // [R2]

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rx_busy <= 1'b0;
		end else if (!radio_ok || RX_DONE) begin
			rx_busy <= 1'b0;
		end else if (SYNC_FOUND && !TX_REQ) begin
			rx_busy <= 1'b1; // [R17]
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			RADIO <= RADIO_IDLE;
		end else begin
			RADIO.radio_power <= radio_ok; // [R6]
			RADIO.tx_active <= radio_ok && TX_REQ;
			RADIO.rx_data <= radio_ok && !TX_REQ && rx_busy; // [R17]
			RADIO.rx_search <= radio_ok && !TX_REQ && !rx_busy;
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			SERIAL_POWER <= 1'b0;
			FAULT_READABLE <= 1'b0;
			SETTINGS_CLEAR <= 1'b1;
		end else begin
			SERIAL_POWER <= (state != ST_OFF) && (state != ST_RESTART);
			FAULT_READABLE <= (state == ST_SAFE); // [R3]
			SETTINGS_CLEAR <= (state == ST_OFF); // [R5]
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			tx_prev <= 1'b0;
		end else begin
			tx_prev <= RADIO.tx_active;
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			STATUS_PIN <= 1'b0;
		end else if (state == ST_FAULT || state == ST_SAFE) begin
			STATUS_PIN <= blink; // [R1]
		end else if (state != ST_ON) begin
			STATUS_PIN <= 1'b0; // [R19]
		end else if (RADIO.tx_active) begin
			if (!tx_prev) begin
				STATUS_PIN <= !STATUS_PIN;
			end
		end else begin
			STATUS_PIN <= !RADIO.rx_data;
		end
	end

	// Power save: interval study and sleep/wake timing.
	assign ps_run = PS_ENABLE && (state == ST_ON);
	assign good_pkt = ps_run && RX_DONE && RX_GOOD;
	assign study_done = (pkt_cnt == STUDY_PKTS);
	assign ps_asleep = (sleep_left != '0);
	assign ival = start_ms - last_start;
	assign marg = (tmin >> MARG_SHIFT) + MARG_ADD_MS; // [R12]
	assign overlap = marg + OVERLAP_ADD_MS; // [R14]
	assign t_less_marg = (tmin > marg) ? tmin - marg : '0;
	assign t_sleep = (t_less_marg > TX_AIRTIME_MS) ?
		t_less_marg - TX_AIRTIME_MS : '0; // [R13]
	assign since_last = ms_now - last_start;
	assign slot_missed = ps_run && study_done && !rx_busy &&
		(since_last > tmin + overlap); // [R14]
	assign study_restart = slot_missed ||
		(good_pkt && study_done && cyc_cnt == CYCLE_LIMIT - 7'h01); // [R15]

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			start_ms <= '0;
		end else if (radio_ok && SYNC_FOUND && !rx_busy) begin
			start_ms <= ms_now; // [R20]
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			tmin <= MS_MAX;
			pkt_cnt <= '0;
			have_last <= 1'b0;
			last_start <= '0;
		end else if (!ps_run || study_restart) begin
			tmin <= MS_MAX; // [R15]
			pkt_cnt <= '0;
			have_last <= 1'b0;
		end else if (good_pkt) begin
			last_start <= start_ms;
			have_last <= 1'b1;
			if (have_last && ival < tmin) begin
				tmin <= ival; // [R11]
			end
			if (!study_done) begin
				pkt_cnt <= pkt_cnt + 3'h1; // [R10]
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cyc_cnt <= '0;
			sleep_left <= '0;
		end else if (!ps_run || study_restart) begin
			cyc_cnt <= '0;
			sleep_left <= '0;
		end else if (good_pkt && study_done) begin
			cyc_cnt <= cyc_cnt + 7'h01; // [R15]
			sleep_left <= t_sleep; // [R13]
		end else if (ms_tick && ps_asleep) begin
			sleep_left <= sleep_left - 16'h0001;
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			PKT_LOST <= 1'b0;
			PS_TMIN_MS <= MS_MAX;
		end else begin
			PKT_LOST <= slot_missed; // [R15]
			PS_TMIN_MS <= tmin;
		end
	end

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!rst_n);

	sequence s_fault_held;
		(state == ST_FAULT || state == ST_SAFE) ##1
			(state == ST_FAULT || state == ST_SAFE);
	endsequence

	sequence s_search_then_sync;
		RADIO.rx_search ##0 (SYNC_FOUND && radio_ok && !TX_REQ);
	endsequence

	a_fault_radio_off: assert property ( // [R2]
		s_fault_held |-> RADIO == RADIO_IDLE)
		else $error("radio active during fault");

	a_enable_low_off: assert property ( // [R5]
		!MODULE_ENABLE_PIN |=> state == ST_OFF ##1 SETTINGS_CLEAR)
		else $error("enable low did not reach off");

	a_enable_high_on: assert property ( // [R4]
		state == ST_OFF && MODULE_ENABLE_PIN |=> state == ST_ON)
		else $error("enable high did not reach on");

	a_sleep_status_low: assert property ( // [R19]
		state == ST_SLEEP ##1 state == ST_SLEEP |-> !STATUS_PIN &&
			!RADIO.radio_power && SERIAL_POWER)
		else $error("sleep outputs wrong");

	a_wake_qualify: assert property ( // [R7]
		wake |-> $past(HOST_TRANSMIT_LINE != line_ref, 1) &&
			wake_cnt == 12'(WAKE_PULSE_CYC - 1) ##1 state == ST_ON)
		else $error("wake without qualified pulse");

	a_wake_ok_time: assert property ( // [R8]
		WAKE_OK |-> ok_ms == TMS_W'(WAKE_OK_MS - 2) && state == ST_ON)
		else $error("ok sent at wrong time");

	a_reboot_5s: assert property ( // [R21]
		state == ST_FAULT && next_state == ST_SAFE |->
			safe_ms == TMS_W'(REBOOT_MS - 1) ##1
			CPU_RESET_REQ && state == ST_SAFE ##1 FAULT_READABLE)
		else $error("reboot timing wrong");

	a_restart_reboot: assert property ( // [R18]
		state == ST_RESTART ##1 state == ST_ON |-> CPU_RESET_REQ &&
			$past(!SERIAL_POWER, 1))
		else $error("restart did not reboot");

	a_search_to_rx: assert property ( // [R17]
		s_search_then_sync ##1 (radio_ok && !TX_REQ && !RX_DONE) |=>
			RADIO.rx_data)
		else $error("sync did not start receive");

	a_lost_restarts: assert property ( // [R15]
		slot_missed |=> PKT_LOST && pkt_cnt == '0 && tmin == MS_MAX)
		else $error("missed slot did not restart study");

	a_sleep_bounded: assert property ( // [R13]
		good_pkt && study_done && !study_restart |=>
			sleep_left <= tmin - marg)
		else $error("sleep period too long");
endmodule

// [bench/rpmc_host.sv]
// Host terminal model that wakes the module and waits for its answer.
`timescale 1ns/1ps
module rpmc_host (
	input wire logic clk,
	input wire logic wake_ok,
	output logic tx_line
);
	initial tx_line = 1'b1;
	// Pulls the idle-high line low for n cycles, then releases it.
	task automatic toggle(input int n);
		@(negedge clk) tx_line = 1'b0;
		repeat (n) @(negedge clk);
		tx_line = 1'b1;
	endtask
	// Nothing else is sent until the answer is seen or the limit runs out.
	task automatic wait_ok(input int lim, output bit ok);
		ok = 1'b0;
		for (int i = 0; i < lim && !ok; i++) begin
			@(negedge clk);
			if (wake_ok === 1'b1) ok = 1'b1;
		end
	endtask
endmodule

// [bench/radio_power_mode_controller_tb.sv]
// Self-checking bench of the radio power mode controller.
`timescale 1ns/1ps
module radio_power_mode_controller_tb;
	import rpmc_pkg::*;
	// A short millisecond tick keeps the five second reboot affordable.
	localparam int MSC = 10;
	logic clk, rst_b, en, host_line, fault, sleep_c, restart_c, ps_en;
	logic tx_req, sync_f, rx_done, rx_good;
	logic [TMS_W-1:0] airtime;
	rpmc_radio_s radio;
	logic ser_pwr, status, wake_ok, f_read, cpu_rst, set_clr, lost;
	logic [TMS_W-1:0] tmin;
	int n_fail = 0;
	int samples_checked = 0;

	rpmc_top #(.MS_CYC(MSC)) i_rpmc_top (.REF_CLK(clk), .RST_B(rst_b),
		.MODULE_ENABLE_PIN(en), .HOST_TRANSMIT_LINE(host_line),
		.FAULT_DETECT(fault), .SLEEP_CMD(sleep_c), .RESTART_CMD(restart_c),
		.PS_ENABLE(ps_en), .TX_REQ(tx_req), .SYNC_FOUND(sync_f),
		.RX_DONE(rx_done), .RX_GOOD(rx_good), .TX_AIRTIME_MS(airtime),
		.RADIO(radio), .SERIAL_POWER(ser_pwr), .STATUS_PIN(status),
		.WAKE_OK(wake_ok), .FAULT_READABLE(f_read), .CPU_RESET_REQ(cpu_rst),
		.SETTINGS_CLEAR(set_clr), .PKT_LOST(lost), .PS_TMIN_MS(tmin));
	rpmc_host i_rpmc_host (.clk(clk), .wake_ok(wake_ok), .tx_line(host_line));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic final_report();
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	// Counts cycles until a reboot request, a lost packet or a status edge.
	task automatic wait_sig(input int sel, input int lim, output int t);
		logic s0;
		s0 = status;
		for (t = 0; t < lim; t++) begin
			@(negedge clk);
			if (sel == 0 && cpu_rst === 1'b1) break;
			if (sel == 1 && lost === 1'b1) break;
			if (sel == 2 && status !== s0) break;
		end
	endtask
	// Sync start to sync start spacing is exactly gap_ms ticks.
	task automatic pkt(input int gap_ms);
		pulse(sync_f);
		cyc(4);
		rx_good = 1'b1;
		pulse(rx_done);
		rx_good = 1'b0;
		cyc(gap_ms * MSC - 6);
	endtask

	task automatic t_rx();
		chk(radio, 4'hc, "search radio");
		chk(status, 1'b1, "search status");
		pulse(sync_f);
		cyc(3);
		chk(radio, 4'ha, "receive radio");
		chk(status, 1'b0, "receive status");
		pulse(rx_done);
		cyc(3);
		chk(radio, 4'hc, "back to search");
		tx_req = 1'b1;
		cyc(3);
		chk(radio.tx_active, 1'b1, "transmit");
		tx_req = 1'b0;
		cyc(3);
	endtask

	task automatic t_sleep();
		bit ok;
		pulse(sleep_c);
		cyc(3);
		chk(radio, 4'h0, "sleep radio");
		chk(ser_pwr, 1'b1, "sleep serial");
		chk(status, 1'b0, "sleep status");
		i_rpmc_host.toggle(1000);
		cyc(20);
		chk(radio, 4'h0, "short pulse wake");
		i_rpmc_host.toggle(1300);
		i_rpmc_host.wait_ok(260, ok);
		chk(ok, 1'b1, "wake answer");
		cyc(1000);
		chk(radio, 4'hc, "stays awake");
	endtask

	task automatic t_ps();
		int t;
		ps_en = 1'b1;
		airtime = 16'h0032;
		cyc(10);
		pkt(400);
		pkt(400);
		chk(tmin, 16'h0190, "first interval");
		pkt(300);
		pkt(300);
		chk(tmin, 16'h012c, "shorter interval");
		pkt(1);
		// Sleep is 300 - (37 + 60) - 50 = 153 ms.
		cyc(145 * MSC);
		chk(radio, 4'h0, "ps asleep");
		cyc(20 * MSC);
		chk(radio.radio_power, 1'b1, "ps awake");
		// Slot closes 300 + 97 + 100 = 497 ms after the last start.
		// About 166 ms of that has passed already, so 332 ms remain.
		wait_sig(1, 400 * MSC, t);
		chk(t >= 3300 && t <= 3330, 1'b1, "missed slot");
		ps_en = 1'b0;
		airtime = '0;
		cyc(10);
	endtask

	task automatic t_enable();
		en = 1'b0;
		cyc(4);
		chk(set_clr, 1'b1, "off clear");
		chk(ser_pwr, 1'b0, "off serial");
		chk(radio, 4'h0, "off radio");
		chk(tmin, 16'hffff, "off interval");
		en = 1'b1;
		cyc(4);
		chk(set_clr, 1'b0, "on clear");
		chk(radio, 4'hc, "on radio");
	endtask

	task automatic t_fault();
		int tb, tr;
		pulse(fault);
		cyc(3);
		chk(radio, 4'h0, "fault radio");
		tx_req = 1'b1;
		pulse(sync_f);
		cyc(2);
		chk(radio, 4'h0, "fault blocks");
		tx_req = 1'b0;
		fork
			begin
				wait_sig(2, 3000, tb);
				wait_sig(2, 3000, tb);
			end
			wait_sig(0, 51000, tr);
		join
		chk(tb + 1, 16'd2500, "blink period");
		chk(tr >= 49980 && tr <= 50010, 1'b1, "reboot time");
		cyc(3);
		chk(f_read, 1'b1, "safe readable");
		chk(radio, 4'h0, "safe radio");
		pulse(restart_c);
		cyc(2);
		chk(ser_pwr, 1'b0, "restart shutdown");
		wait_sig(0, 40, tr);
		chk(tr < 40, 1'b1, "restart reboot");
		cyc(3);
		chk(radio.radio_power, 1'b1, "restart on");
	endtask

	initial begin
		rst_b = 1'b0;
		en = 1'b1;
		{fault, sleep_c, restart_c, ps_en} = 4'h0;
		{tx_req, sync_f, rx_done, rx_good} = 4'h0;
		airtime = '0;
		cyc(3);
		chk(set_clr, 1'b1, "reset clear");
		chk(tmin, 16'hffff, "reset interval");
		rst_b = 1'b1;
		cyc(6);
		chk(ser_pwr, 1'b1, "power up on");
		t_rx();
		t_sleep();
		t_ps();
		t_enable();
		t_fault();
		final_report();
	end

	initial begin
		cyc(100000);
		n_fail++;
		$display("[ERR] %0t watchdog expired", $time);
		final_report();
	end
endmodule
